/* hdl/sswc_consts.svh */
`ifndef SSWC_CONSTS_SVH
`define SSWC_CONSTS_SVH
// Sleep state codes on sleep_state input
`define SSWC_ST_S0 3'h0
`define SSWC_ST_S1 3'h1
`define SSWC_ST_S3 3'h3
`define SSWC_ST_S4 3'h4
`define SSWC_ST_S5 3'h5
// Led blink half period
`define SSWC_BLINK_NS 500000000
`define SSWC_CLK_NS 10
`define SSWC_BLINK_CYC (`SSWC_BLINK_NS / `SSWC_CLK_NS)
`define SSWC_BLINK_W 26
`endif

/* hdl/sswc_pkg.sv */
package sswc_pkg;
   typedef enum logic [1:0] {
      SSWC_WORKING,
      SSWC_SLEEPING,
      SSWC_WAKING
   } sswc_fsm_t;
endpackage

/* hdl/sswc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sswc_consts.svh"
// Contract
// - Fan runs while working.
// - Fan off when powered off or in S3, S4, S5.
// - Configured LAN wake frame raises a wake request.
// - In S3 the LED blinks, fan and drives stay off.
// - Wake from S3 returns to the state held before sleep.
// - USB activity wakes only from S1 and S3.
// - USB port power is off in S4 and S5.
// - PME line wakes from S1, S3, S4, S5 when enabled.
// - PCIe wake line wakes from S1, S3, S4, S5.
// - PCIe wake line has a firmware enable.
// - Keyboard activity wakes from S1, S3, S4, S5.
// - In S4/S5 the keyboard wakes only with the key combo or power key.
// - Firmware picks combo or power key for S5 wake.
// - Serial activity wakes only from S1 and S3.
// - S5 wake works also after a power loss.
module sswc_top
   import sswc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] sleep_state,
   input wire logic power_lost,
   input wire logic lan_wake,
   input wire logic pme_n,
   input wire logic pme_en,
   input wire logic pcie_wake_n,
   input wire logic pcie_wake_en,
   input wire logic usb_activity,
   input wire logic serial_activity,
   input wire logic kbd_activity,
   input wire logic kbd_combo,
   input wire logic kbd_power_key,
   input wire logic kbd_s5_sel_power,
   output logic wake_req,
   output logic resume_ctx,
   output logic fan_on,
   output logic drive_pwr,
   output logic usb_pwr,
   output logic led_on
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      sswc_fsm_t fsm;
      logic [2:0] slept;
      logic wake;
      logic resume;
      logic fan;
      logic drv;
      logic usb;
      logic led;
      logic [`SSWC_BLINK_W-1:0] cnt;
   } sswc_state_t;

   sswc_state_t s_q;
   sswc_state_t s_d;
   logic qual;
   logic [2:0] eff_state;

   // Power loss lands the board in soft-off, so S5 wake still applies
   assign eff_state = power_lost ? `SSWC_ST_S5 : sleep_state;

   sswc_wake_qual u_qual (
      .state(eff_state),
      .lan_wake(lan_wake),
      .pme_n(pme_n),
      .pme_en(pme_en),
      .pcie_wake_n(pcie_wake_n),
      .pcie_wake_en(pcie_wake_en),
      .usb_activity(usb_activity),
      .serial_activity(serial_activity),
      .kbd_activity(kbd_activity),
      .kbd_combo(kbd_combo),
      .kbd_power_key(kbd_power_key),
      .kbd_s5_sel_power(kbd_s5_sel_power),
      .wake(qual)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      s_d.wake = 1'b0;
      s_d.resume = 1'b0;
      s_d.fan = (eff_state == `SSWC_ST_S0);
      s_d.drv = (eff_state == `SSWC_ST_S0) || (eff_state == `SSWC_ST_S1);
      s_d.usb = !((eff_state == `SSWC_ST_S4) ||
         (eff_state == `SSWC_ST_S5));
      if (eff_state == `SSWC_ST_S3) begin
         s_d.drv = 1'b0;
         if (s_q.cnt == `SSWC_BLINK_W'(`SSWC_BLINK_CYC - 1)) begin
            s_d.cnt = '0;
            s_d.led = !s_q.led;
         end else begin
            s_d.cnt = s_q.cnt + `SSWC_BLINK_W'(1);
         end
      end else begin
         s_d.cnt = '0;
         s_d.led = (eff_state == `SSWC_ST_S0) || (eff_state == `SSWC_ST_S1);
      end
      unique case (s_q.fsm)
         SSWC_WORKING: begin
            // Requests while working are dropped
            if (eff_state != `SSWC_ST_S0) begin
               s_d.fsm = SSWC_SLEEPING;
            end
         end
         SSWC_SLEEPING: begin
            if (eff_state == `SSWC_ST_S0) begin
               s_d.fsm = SSWC_WORKING;
            end else if (qual) begin
               s_d.fsm = SSWC_WAKING;
               s_d.slept = eff_state;
               s_d.wake = 1'b1;
               s_d.resume = (eff_state == `SSWC_ST_S3) ||
                  (eff_state == `SSWC_ST_S1);
            end
         end
         SSWC_WAKING: begin
            // Hold until the host reports working again
            if (eff_state == `SSWC_ST_S0) begin
               s_d.fsm = SSWC_WORKING;
            end
         end
         default: s_d.fsm = SSWC_WORKING;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '{fsm: SSWC_WORKING, slept: 3'h0, wake: 1'b0, resume: 1'b0,
            fan: 1'b0, drv: 1'b0, usb: 1'b0, led: 1'b0, cnt: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign wake_req = s_q.wake;
   assign resume_ctx = s_q.resume;
   assign fan_on = s_q.fan;
   assign drive_pwr = s_q.drv;
   assign usb_pwr = s_q.usb;
   assign led_on = s_q.led;

   // ****************************************
   // Checks
   // ****************************************
   a_fan_working: assert property (
      @(posedge clk) disable iff (!resetn)
      eff_state == `SSWC_ST_S0 |=> fan_on)
      else $error("fan off while working");
   a_fan_sleep: assert property (
      @(posedge clk) disable iff (!resetn)
      eff_state >= `SSWC_ST_S3 |=> !fan_on && !drive_pwr)
      else $error("fan or drives on in deep sleep");
   a_usb_off: assert property (
      @(posedge clk) disable iff (!resetn)
      eff_state >= `SSWC_ST_S4 |=> !usb_pwr)
      else $error("usb powered in S4 or S5");
   a_no_wake_s0: assert property (
      @(posedge clk) disable iff (!resetn)
      s_q.fsm == SSWC_WORKING |=> !wake_req)
      else $error("wake while working");
   a_usb_deep: assert property (
      @(posedge clk) disable iff (!resetn)
      eff_state >= `SSWC_ST_S4 && !lan_wake && pme_n && pcie_wake_n
      && !kbd_activity |-> !qual)
      else $error("usb or serial woke deep state");
   a_pme_wake: assert property (
      @(posedge clk) disable iff (!resetn)
      s_q.fsm == SSWC_SLEEPING && eff_state != `SSWC_ST_S0 && !pme_n
      && pme_en |=> wake_req)
      else $error("pme did not wake");
   a_pcie_dis: assert property (
      @(posedge clk) disable iff (!resetn)
      !pcie_wake_en && !lan_wake && (pme_n || !pme_en) && !usb_activity
      && !serial_activity && !kbd_activity |-> !qual)
      else $error("disabled pcie wake woke");
   a_resume_s3: assert property (
      @(posedge clk) disable iff (!resetn)
      wake_req && s_q.slept == `SSWC_ST_S3 |-> resume_ctx)
      else $error("s3 wake without resume");
   a_led_blink: assert property (
      @(posedge clk) disable iff (!resetn)
      eff_state == `SSWC_ST_S3 && $past(eff_state) == `SSWC_ST_S3
      && $past(s_q.cnt) == `SSWC_BLINK_W'(`SSWC_BLINK_CYC - 1)
      |-> led_on != $past(led_on))
      else $error("led did not toggle");

   // ****************************************
   // Blink, S3 power and wake checks
   // ****************************************
   // Full blink period is too long to watch, so the count is checked
   a_blink_count: assert property (
      @(posedge clk) disable iff (!resetn)
      $past(resetn) && $past(eff_state) == `SSWC_ST_S3
      && $past(s_q.cnt) != `SSWC_BLINK_W'(`SSWC_BLINK_CYC - 1)
      |-> s_q.cnt == $past(s_q.cnt) + `SSWC_BLINK_W'(1))
      else $error("blink counter stalled in S3");
   a_drive_s3: assert property (
      @(posedge clk) disable iff (!resetn)
      eff_state == `SSWC_ST_S3 |=> !drive_pwr && !fan_on)
      else $error("fan or drives on in S3");
   a_wake_once: assert property (
      @(posedge clk) disable iff (!resetn)
      s_q.fsm == SSWC_WAKING |=> !wake_req)
      else $error("second wake before working");
   a_lan_wake: assert property (
      @(posedge clk) disable iff (!resetn)
      s_q.fsm == SSWC_SLEEPING && lan_wake && (eff_state inside
      {`SSWC_ST_S1, `SSWC_ST_S3, `SSWC_ST_S4, `SSWC_ST_S5}) |=> wake_req)
      else $error("lan wake frame did not wake");
   a_pcie_wake: assert property (
      @(posedge clk) disable iff (!resetn)
      s_q.fsm == SSWC_SLEEPING && !pcie_wake_n && pcie_wake_en
      && (eff_state inside {`SSWC_ST_S1, `SSWC_ST_S3, `SSWC_ST_S4,
      `SSWC_ST_S5}) |=> wake_req)
      else $error("pcie wake did not wake");
   a_usb_light: assert property (
      @(posedge clk) disable iff (!resetn)
      s_q.fsm == SSWC_SLEEPING && usb_activity
      && (eff_state inside {`SSWC_ST_S1, `SSWC_ST_S3}) |=> wake_req)
      else $error("usb did not wake light sleep");
   a_kbd_deep: assert property (
      @(posedge clk) disable iff (!resetn)
      eff_state inside {`SSWC_ST_S4, `SSWC_ST_S5} && !lan_wake && pme_n
      && pcie_wake_n && !kbd_combo && !kbd_power_key |-> !qual)
      else $error("plain key woke deep state");
   a_kbd_sel: assert property (
      @(posedge clk) disable iff (!resetn)
      eff_state == `SSWC_ST_S5 && kbd_s5_sel_power && !kbd_power_key
      && !lan_wake && pme_n && pcie_wake_n |-> !qual)
      else $error("unselected key woke soft-off");
   a_power_loss: assert property (
      @(posedge clk) disable iff (!resetn)
      power_lost && s_q.fsm == SSWC_SLEEPING && !pme_n && pme_en
      |=> wake_req)
      else $error("no wake after power loss");
   a_resume_deep: assert property (
      @(posedge clk) disable iff (!resetn)
      wake_req && s_q.slept inside {`SSWC_ST_S4, `SSWC_ST_S5} |-> !resume_ctx)
      else $error("resume flagged after deep wake");
endmodule
`default_nettype wire

/* hdl/sswc_wake_qual.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sswc_consts.svh"
// ****************************************
// Wake source qualifier, combinational
// ****************************************
module sswc_wake_qual
   import sswc_pkg::*;
(
   input wire logic [2:0] state,
   input wire logic lan_wake,
   input wire logic pme_n,
   input wire logic pme_en,
   input wire logic pcie_wake_n,
   input wire logic pcie_wake_en,
   input wire logic usb_activity,
   input wire logic serial_activity,
   input wire logic kbd_activity,
   input wire logic kbd_combo,
   input wire logic kbd_power_key,
   input wire logic kbd_s5_sel_power,
   output logic wake
);
   logic light;
   logic deep;
   logic kbd_ok;
   always_comb begin
      light = (state == `SSWC_ST_S1) || (state == `SSWC_ST_S3);
      deep = (state == `SSWC_ST_S4) || (state == `SSWC_ST_S5);
      // Deep states take only the special keys
      if (state == `SSWC_ST_S5) begin
         kbd_ok = kbd_s5_sel_power ? kbd_power_key : kbd_combo;
      end else begin
         kbd_ok = kbd_combo || kbd_power_key;
      end
      wake = ((light || deep) && lan_wake)
         || ((light || deep) && !pme_n && pme_en)
         || ((light || deep) && !pcie_wake_n && pcie_wake_en)
         || (light && usb_activity)
         || (light && serial_activity)
         || (light && kbd_activity)
         || (deep && kbd_activity && kbd_ok);
   end
endmodule
`default_nettype wire

/* verif/sleep_state_wake_controller_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sleep_state_wake_controller_test;
   typedef struct packed {
      logic [2:0] st;
      logic [2:0] src;
      logic [2:0] en;
      logic exp;
   } sswc_row_t;
   // Src: lan,pme,pcie,usb,serial,kbd,combo,powerkey; en: pme,pcie,sel
   sswc_row_t rows [23] = '{
      '{3'h1,3'h3,3'h0,1'h1}, '{3'h3,3'h3,3'h0,1'h1},
      '{3'h4,3'h3,3'h0,1'h0}, '{3'h5,3'h3,3'h0,1'h0},
      '{3'h3,3'h4,3'h0,1'h1}, '{3'h5,3'h4,3'h0,1'h0},
      '{3'h1,3'h0,3'h0,1'h1}, '{3'h5,3'h0,3'h0,1'h1},
      '{3'h3,3'h1,3'h4,1'h1}, '{3'h5,3'h1,3'h0,1'h0},
      '{3'h4,3'h2,3'h2,1'h1}, '{3'h5,3'h2,3'h0,1'h0},
      '{3'h3,3'h5,3'h0,1'h1}, '{3'h4,3'h5,3'h0,1'h0},
      '{3'h4,3'h7,3'h0,1'h1}, '{3'h5,3'h6,3'h0,1'h1},
      '{3'h5,3'h7,3'h0,1'h0}, '{3'h5,3'h7,3'h1,1'h1},
      '{3'h5,3'h6,3'h1,1'h0}, '{3'h4,3'h1,3'h4,1'h1},
      '{3'h1,3'h2,3'h2,1'h1}, '{3'h5,3'h2,3'h2,1'h1},
      '{3'h0,3'h3,3'h7,1'h0}};
   sswc_row_t r;
   logic clk, resetn, power_lost, pme_en, pcie_wake_en, sel_pwr, fire, ctx;
   logic [2:0] sleep_state, src;
   logic [1:0] hits;
   logic lan_wake, pme_n, pcie_wake_n, usb_activity, serial_activity;
   logic kbd_activity, kbd_combo, kbd_power_key;
   logic wake_req, resume_ctx, fan_on, drive_pwr, usb_pwr, led_on;
   int n_mismatch = 0;
   int num_checks = 0;
   sswc_peer peer_u (.src(src), .fire(fire), .lan_wake(lan_wake),
      .pme_n(pme_n), .pcie_wake_n(pcie_wake_n), .usb_activity(usb_activity),
      .serial_activity(serial_activity), .kbd_activity(kbd_activity),
      .kbd_combo(kbd_combo), .kbd_power_key(kbd_power_key));
   sswc_top dut_u (.clk(clk), .resetn(resetn), .sleep_state(sleep_state),
      .power_lost(power_lost), .lan_wake(lan_wake), .pme_n(pme_n),
      .pme_en(pme_en), .pcie_wake_n(pcie_wake_n),
      .pcie_wake_en(pcie_wake_en), .usb_activity(usb_activity),
      .serial_activity(serial_activity), .kbd_activity(kbd_activity),
      .kbd_combo(kbd_combo), .kbd_power_key(kbd_power_key),
      .kbd_s5_sel_power(sel_pwr), .wake_req(wake_req),
      .resume_ctx(resume_ctx), .fan_on(fan_on), .drive_pwr(drive_pwr),
      .usb_pwr(usb_pwr), .led_on(led_on));
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Sleep is entered from S0 so the wake logic is re-armed
   task automatic enter(input logic [2:0] st);
      sleep_state = 3'h0;
      repeat (3) @(negedge clk);
      sleep_state = st;
      repeat (3) @(negedge clk);
   endtask
   task automatic fire_src(input logic [2:0] s);
      src = s;
      fire = 1'b1;
      hits = 2'h0;
      ctx = 1'b0;
      @(negedge clk);
      fire = 1'b0;
      repeat (4) begin
         if (wake_req === 1'b1) begin
            hits++;
            ctx = resume_ctx;
         end
         @(negedge clk);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end
   initial begin
      {resetn, power_lost, pme_en, pcie_wake_en, sel_pwr, fire} = 6'h0;
      sleep_state = 3'h0;
      src = 3'h0;
      repeat (8) @(negedge clk);
      chk(fan_on | drive_pwr | usb_pwr | led_on | wake_req, 2'h0);
      resetn = 1'b1;
      // Led blink half period is too long to watch here
      for (int i = 0; i < 23; i++) begin
         r = rows[i];
         {pme_en, pcie_wake_en, sel_pwr} = r.en;
         enter(r.st);
         if (r.st != 3'h1) chk(fan_on, r.st == 3'h0);
         chk(drive_pwr, r.st <= 3'h1);
         chk(usb_pwr, r.st <= 3'h3);
         if (r.st != 3'h3) chk(led_on, r.st <= 3'h1);
         fire_src(r.src);
         chk(hits, {1'b0, r.exp});
         if (hits == 2'h1) chk(ctx, r.st <= 3'h3);
      end
      $display("row tests done");
      enter(3'h3);
      fire_src(3'h3);
      chk(hits, 2'h1);
      fire_src(3'h3);
      chk(hits, 2'h0);
      $display("repeat wake test done");
      // Reset in mid-sleep must leave the block able to wake again
      enter(3'h3);
      resetn = 1'b0;
      @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      chk(usb_pwr, 2'h1);
      chk(fan_on | drive_pwr, 2'h0);
      fire_src(3'h3);
      chk(hits, 2'h1);
      $display("mid-run reset test done");
      // Host still reports S0, the power loss alone must arm soft-off wake
      pme_en = 1'b1;
      enter(3'h0);
      power_lost = 1'b1;
      repeat (3) @(negedge clk);
      chk(usb_pwr | fan_on, 2'h0);
      fire_src(3'h1);
      chk(hits, 2'h1);
      chk(ctx, 2'h0);
      $display("power loss test done");
      end_sim();
   end
endmodule
`default_nettype wire

/* verif/sswc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Peripheral wake sources
// ****************************************
// Active low lines idle high, as with their pull-ups
module sswc_peer (
   input wire logic [2:0] src,
   input wire logic fire,
   output logic lan_wake,
   output logic pme_n,
   output logic pcie_wake_n,
   output logic usb_activity,
   output logic serial_activity,
   output logic kbd_activity,
   output logic kbd_combo,
   output logic kbd_power_key
);
   always_comb begin
      lan_wake = fire && src == 3'h0;
      pme_n = !(fire && src == 3'h1);
      pcie_wake_n = !(fire && src == 3'h2);
      usb_activity = fire && src == 3'h3;
      serial_activity = fire && src == 3'h4;
      kbd_activity = fire && src >= 3'h5;
      kbd_combo = fire && src == 3'h6;
      kbd_power_key = fire && src == 3'h7;
   end
endmodule
`default_nettype wire
